// *** rtl/cos_defs.svh ***
// Notes on behaviour
// - Per-channel coupling membership set is held.
// - Independent turn-on delay per channel, any order.
// - No common offset: module offset plus delay.
// - Common offset elapses before channel delay counts.
// - Largest installed module offset is readable.
// - Larger common offset accepted without error.
// - Shorter common offset accepted, alignment not guaranteed.
// - Off event starts turn-off delays immediately.
// - Sync function only on lines four to seven.
// - At most one on line, one off line.
// - Sync lines active low, polarity setting ignored.
// - Initiator drives falling edge, all frames act.
// - Any switch request moves all coupled channels while sync is enabled; when disabled, requests are ignored but running delays still finish.
`ifndef COS_DEFS_SVH
`define COS_DEFS_SVH

`define COS_ADDR_W 8
`define COS_DLY_W 24
`define COS_NPIN 7

`define COS_REG_CTRL 8'h00
`define COS_REG_CHAN 8'h04
`define COS_REG_COFS 8'h08
`define COS_REG_MAXOFS 8'h0C
`define COS_REG_PINCFG 8'h10
`define COS_REG_STATUS 8'h14
`define COS_REG_GPIO 8'h18
`define COS_REG_ONDLY 8'h20
`define COS_REG_OFFDLY 8'h40

`define COS_CTRL_EN 0
`define COS_CTRL_ON 1
`define COS_CTRL_OFF 2
`define COS_PIN_ON_LSB 0
`define COS_PIN_OFF_LSB 4
`define COS_STAT_ERR 8
`define COS_STAT_DRV_ON 9
`define COS_STAT_DRV_OFF 10
`define COS_GPIO_POL_LSB 8
`define COS_GPIO_DIR_LSB 16
`define COS_SYNC_PIN_MIN 3'h4

`define COS_CLK_PERIOD_NS 10
`define COS_TICK_NS 1000
`define COS_TICK_CYC ((`COS_TICK_NS + `COS_CLK_PERIOD_NS - 1) / `COS_CLK_PERIOD_NS)
`define COS_SYNC_PULSE_NS 2000
`define COS_SYNC_PULSE_CYC ((`COS_SYNC_PULSE_NS + `COS_CLK_PERIOD_NS - 1) / `COS_CLK_PERIOD_NS)
`define COS_ECHO_GUARD_CYC 4
`define COS_LCNT_W 9

`endif

// *** rtl/cos_pkg.sv ***
`include "cos_defs.svh"
package cos_pkg;
  typedef struct packed {
    logic [`COS_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } cos_bus_req_t;

  typedef struct packed {
    logic [`COS_DLY_W-1:0] on_dly;
    logic [`COS_DLY_W-1:0] off_dly;
  } cos_chan_cfg_t;

  typedef enum logic [1:0] {
    CS_IDLE,
    CS_OFS,
    CS_ON,
    CS_OFF
  } cos_chan_state_t;
endpackage : cos_pkg

// *** rtl/cos_chan.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cos_defs.svh"
module cos_chan (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Timing and events
  input wire logic tick_i,
  input wire logic coupled_i,
  input wire logic on_evt_i,
  input wire logic off_evt_i,
  // Settings, in ticks
  input wire logic [`COS_DLY_W-1:0] cofs_i,
  input wire logic [`COS_DLY_W-1:0] mofs_i,
  input wire cos_pkg::cos_chan_cfg_t cfg_i,
  // State
  output var logic on_o
);
  import cos_pkg::*;

  cos_chan_state_t state_r, state_nxt;
  logic [`COS_DLY_W:0] cnt_r, cnt_nxt;
  logic on_r, on_nxt;
  logic waiting;

  assign waiting = (state_r != CS_IDLE);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    on_nxt = on_r;
    if (coupled_i && off_evt_i) begin
      state_nxt = CS_OFF;
      cnt_nxt = {1'b0, cfg_i.off_dly};
    end else if (coupled_i && on_evt_i) begin
      if (cofs_i != '0) begin
        state_nxt = CS_OFS;
        cnt_nxt = {1'b0, cofs_i};
      end else begin
        state_nxt = CS_ON;
        cnt_nxt = {1'b0, mofs_i} + {1'b0, cfg_i.on_dly};
      end
    end else if (waiting) begin
      if (cnt_r == '0) begin
        case (state_r)
          CS_OFS: begin
            state_nxt = CS_ON;
            cnt_nxt = {1'b0, cfg_i.on_dly};
          end
          CS_ON: begin
            state_nxt = CS_IDLE;
            on_nxt = 1'b1;
          end
          CS_OFF: begin
            state_nxt = CS_IDLE;
            on_nxt = 1'b0;
          end
          default: state_nxt = CS_IDLE;
        endcase
      end else if (tick_i) begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_r <= CS_IDLE;
      cnt_r <= '0;
      on_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      on_r <= on_nxt;
    end
  end

  assign on_o = on_r;

  property p_off_now;
    @(posedge clk_i) disable iff (!nrst_i)
    (coupled_i && off_evt_i) |=>
      (state_r == CS_OFF) && (cnt_r == {1'b0, $past(cfg_i.off_dly)});
  endproperty
  a_off_now: assert property (p_off_now)
    else $error("off event did not start turn-off delay");

  property p_ofs_first;
    @(posedge clk_i) disable iff (!nrst_i)
    (coupled_i && on_evt_i && !off_evt_i && cofs_i != '0) |=>
      (state_r == CS_OFS) && (cnt_r == {1'b0, $past(cofs_i)});
  endproperty
  a_ofs_first: assert property (p_ofs_first)
    else $error("common offset not counted first");

  property p_no_ofs;
    @(posedge clk_i) disable iff (!nrst_i)
    (coupled_i && on_evt_i && !off_evt_i && cofs_i == '0) |=>
      (state_r == CS_ON) &&
      (cnt_r == {1'b0, $past(mofs_i)} + {1'b0, $past(cfg_i.on_dly)});
  endproperty
  a_no_ofs: assert property (p_no_ofs)
    else $error("turn-on without offset is not module plus delay");

  property p_uncoupled;
    @(posedge clk_i) disable iff (!nrst_i)
    (!coupled_i && !waiting) |=> $stable(on_r) && !waiting;
  endproperty
  a_uncoupled: assert property (p_uncoupled)
    else $error("uncoupled channel changed state");

  property p_ofs_to_dly;
    @(posedge clk_i) disable iff (!nrst_i)
    (state_r == CS_OFS && cnt_r == '0 && !on_evt_i && !off_evt_i) |=>
      (state_r == CS_ON) && (cnt_r == {1'b0, $past(cfg_i.on_dly)});
  endproperty
  a_ofs_to_dly: assert property (p_ofs_to_dly)
    else $error("own delay did not follow common offset");
endmodule : cos_chan
`default_nettype wire

// *** rtl/cos_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cos_defs.svh"
module cos_sync #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Register port
  input wire cos_pkg::cos_bus_req_t bus_i,
  output logic [31:0] rdata_o,
  // Requests from other interfaces
  input wire logic req_on_i,
  input wire logic req_off_i,
  // Installed modules, offsets in ticks
  input wire logic [N-1:0] mod_present_i,
  input wire logic [N-1:0][`COS_DLY_W-1:0] mod_ofs_i,
  // Digital port, open-drain on sync lines
  input wire logic [`COS_NPIN-1:0] dig_in_i,
  output logic [`COS_NPIN-1:0] dig_out_o,
  output logic [`COS_NPIN-1:0] dig_oe_o,
  // Channel on state
  output logic [N-1:0] chan_on_o
);
  import cos_pkg::*;

  localparam logic [`COS_LCNT_W-1:0] LCNT_LOAD =
    `COS_LCNT_W'(`COS_SYNC_PULSE_CYC + `COS_ECHO_GUARD_CYC);
  localparam logic [`COS_LCNT_W-1:0] LCNT_GUARD =
    `COS_LCNT_W'(`COS_ECHO_GUARD_CYC);
  localparam logic [7:0] TICK_LAST = 8'(`COS_TICK_CYC - 1);

  function automatic logic pin_ok(input logic [2:0] sel);
    pin_ok = (sel == 3'h0) || (sel >= `COS_SYNC_PIN_MIN);
  endfunction : pin_ok

  function automatic logic [`COS_NPIN-1:0] dec_pin(input logic [2:0] sel);
    dec_pin = '0;
    for (int p = 0; p < `COS_NPIN; p++) begin
      dec_pin[p] = (sel == 3'(p + 1));
    end
  endfunction : dec_pin

  logic en_r, en_nxt;
  logic [N-1:0] mask_r, mask_nxt;
  logic [`COS_DLY_W-1:0] cofs_r, cofs_nxt;
  logic [`COS_DLY_W-1:0] maxofs_r, maxofs_nxt;
  logic [2:0] on_pin_r, on_pin_nxt, off_pin_r, off_pin_nxt;
  logic err_r, err_nxt;
  logic [`COS_NPIN-1:0] gp_data_r, gp_data_nxt, gp_pol_r, gp_pol_nxt;
  logic [`COS_NPIN-1:0] gp_dir_r, gp_dir_nxt;
  cos_chan_cfg_t cfg_r [N];
  cos_chan_cfg_t cfg_nxt [N];
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0][`COS_LCNT_W-1:0] lcnt_r, lcnt_nxt;
  logic [1:0] drive_r, drive_nxt;
  logic [`COS_NPIN-1:0] prev_in_r;
  logic [`COS_NPIN-1:0] out_r, out_nxt, oe_r, oe_nxt;
  logic [7:0] tcnt_r, tcnt_nxt;
  logic tick_r, tick_nxt;
  logic [1:0][`COS_NPIN-1:0] hot;
  logic [1:0] loc, fall, evt, start;
  logic [N-1:0] chan_on;
  logic wr_pin, pin_good;
  logic [2:0] w_on, w_off;

  assign w_on = bus_i.wdata[`COS_PIN_ON_LSB +: 3];
  assign w_off = bus_i.wdata[`COS_PIN_OFF_LSB +: 3];
  assign wr_pin = bus_i.we && (bus_i.addr == `COS_REG_PINCFG);
  assign pin_good = pin_ok(w_on) && pin_ok(w_off) &&
    ((w_on != w_off) || (w_on == 3'h0));

  // Configuration registers
  always_comb begin
    en_nxt = en_r;
    mask_nxt = mask_r;
    cofs_nxt = cofs_r;
    on_pin_nxt = on_pin_r;
    off_pin_nxt = off_pin_r;
    gp_data_nxt = gp_data_r;
    gp_pol_nxt = gp_pol_r;
    gp_dir_nxt = gp_dir_r;
    err_nxt = err_r;
    for (int i = 0; i < N; i++) begin
      cfg_nxt[i] = cfg_r[i];
    end
    if (bus_i.we) begin
      case (bus_i.addr)
        `COS_REG_CTRL: en_nxt = bus_i.wdata[`COS_CTRL_EN];
        `COS_REG_CHAN: mask_nxt = bus_i.wdata[N-1:0];
        // Any value kept, larger or smaller than the worst module
        `COS_REG_COFS: cofs_nxt = bus_i.wdata[`COS_DLY_W-1:0];
        `COS_REG_PINCFG: begin
          if (pin_good) begin
            on_pin_nxt = w_on;
            off_pin_nxt = w_off;
          end
        end
        `COS_REG_STATUS: begin
          if (bus_i.wdata[`COS_STAT_ERR]) begin
            err_nxt = 1'b0;
          end
        end
        `COS_REG_GPIO: begin
          gp_data_nxt = bus_i.wdata[`COS_NPIN-1:0];
          gp_pol_nxt = bus_i.wdata[`COS_GPIO_POL_LSB +: `COS_NPIN];
          gp_dir_nxt = bus_i.wdata[`COS_GPIO_DIR_LSB +: `COS_NPIN];
        end
        default: begin
          for (int i = 0; i < N; i++) begin
            if (bus_i.addr == `COS_REG_ONDLY + 8'(4 * i)) begin
              cfg_nxt[i].on_dly = bus_i.wdata[`COS_DLY_W-1:0];
            end
            if (bus_i.addr == `COS_REG_OFFDLY + 8'(4 * i)) begin
              cfg_nxt[i].off_dly = bus_i.wdata[`COS_DLY_W-1:0];
            end
          end
        end
      endcase
    end
    // Refusal flag: a new refusal beats a same-cycle clear
    if (wr_pin && !pin_good) begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      en_r <= 1'b0;
      mask_r <= '0;
      cofs_r <= '0;
      on_pin_r <= 3'h0;
      off_pin_r <= 3'h0;
      gp_data_r <= '0;
      gp_pol_r <= '0;
      gp_dir_r <= '0;
      err_r <= 1'b0;
      for (int i = 0; i < N; i++) begin
        cfg_r[i] <= '0;
      end
    end else begin
      en_r <= en_nxt;
      mask_r <= mask_nxt;
      cofs_r <= cofs_nxt;
      on_pin_r <= on_pin_nxt;
      off_pin_r <= off_pin_nxt;
      gp_data_r <= gp_data_nxt;
      gp_pol_r <= gp_pol_nxt;
      gp_dir_r <= gp_dir_nxt;
      err_r <= err_nxt;
      for (int i = 0; i < N; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
    end
  end

  // Sync lines: index 0 is on, index 1 is off
  assign loc[0] = req_on_i || (bus_i.we && bus_i.addr == `COS_REG_CTRL &&
    bus_i.wdata[`COS_CTRL_ON]);
  assign loc[1] = req_off_i || (bus_i.we && bus_i.addr == `COS_REG_CTRL &&
    bus_i.wdata[`COS_CTRL_OFF]);
  assign hot[0] = dec_pin(on_pin_r);
  assign hot[1] = dec_pin(off_pin_r);

  // Line active low whatever the polarity setting says
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      fall[k] = |(hot[k] & prev_in_r & ~dig_in_i);
      // Own edge lands inside the drive window and is masked
      evt[k] = en_r && (loc[k] || (fall[k] && lcnt_r[k] == '0));
      start[k] = en_r && loc[k] && (|hot[k]) && (lcnt_r[k] == '0);
      if (start[k]) begin
        lcnt_nxt[k] = LCNT_LOAD;
      end else if (lcnt_r[k] != '0) begin
        lcnt_nxt[k] = lcnt_r[k] - 1'b1;
      end else begin
        lcnt_nxt[k] = '0;
      end
      drive_nxt[k] = (lcnt_nxt[k] > LCNT_GUARD);
    end
    for (int p = 0; p < `COS_NPIN; p++) begin
      if (hot[0][p]) begin
        out_nxt[p] = 1'b0;
        oe_nxt[p] = drive_nxt[0];
      end else if (hot[1][p]) begin
        out_nxt[p] = 1'b0;
        oe_nxt[p] = drive_nxt[1];
      end else begin
        out_nxt[p] = gp_data_r[p] ^ gp_pol_r[p];
        oe_nxt[p] = gp_dir_r[p];
      end
    end
  end

  // Tick divider, worst module offset and read port
  always_comb begin
    tick_nxt = (tcnt_r == TICK_LAST);
    tcnt_nxt = tick_nxt ? 8'h00 : tcnt_r + 8'h01;
    maxofs_nxt = '0;
    for (int i = 0; i < N; i++) begin
      if (mod_present_i[i] && mod_ofs_i[i] > maxofs_nxt) begin
        maxofs_nxt = mod_ofs_i[i];
      end
    end
    rdata_nxt = 32'h0000_0000;
    if (bus_i.re) begin
      case (bus_i.addr)
        `COS_REG_CTRL: rdata_nxt[`COS_CTRL_EN] = en_r;
        `COS_REG_CHAN: rdata_nxt[N-1:0] = mask_r;
        `COS_REG_COFS: rdata_nxt[`COS_DLY_W-1:0] = cofs_r;
        `COS_REG_MAXOFS: rdata_nxt[`COS_DLY_W-1:0] = maxofs_r;
        `COS_REG_PINCFG: begin
          rdata_nxt[`COS_PIN_ON_LSB +: 3] = on_pin_r;
          rdata_nxt[`COS_PIN_OFF_LSB +: 3] = off_pin_r;
        end
        `COS_REG_STATUS: begin
          rdata_nxt[N-1:0] = chan_on;
          rdata_nxt[`COS_STAT_ERR] = err_r;
          rdata_nxt[`COS_STAT_DRV_ON] = drive_r[0];
          rdata_nxt[`COS_STAT_DRV_OFF] = drive_r[1];
        end
        `COS_REG_GPIO: begin
          rdata_nxt[`COS_NPIN-1:0] = gp_data_r;
          rdata_nxt[`COS_GPIO_POL_LSB +: `COS_NPIN] = gp_pol_r;
          rdata_nxt[`COS_GPIO_DIR_LSB +: `COS_NPIN] = gp_dir_r;
        end
        default: begin
          for (int i = 0; i < N; i++) begin
            if (bus_i.addr == `COS_REG_ONDLY + 8'(4 * i)) begin
              rdata_nxt[`COS_DLY_W-1:0] = cfg_r[i].on_dly;
            end
            if (bus_i.addr == `COS_REG_OFFDLY + 8'(4 * i)) begin
              rdata_nxt[`COS_DLY_W-1:0] = cfg_r[i].off_dly;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      lcnt_r <= '0;
      drive_r <= 2'h0;
      prev_in_r <= '1;
      out_r <= '0;
      oe_r <= '0;
      tcnt_r <= 8'h00;
      tick_r <= 1'b0;
      maxofs_r <= '0;
      rdata_r <= 32'h0000_0000;
    end else begin
      lcnt_r <= lcnt_nxt;
      drive_r <= drive_nxt;
      prev_in_r <= dig_in_i;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      tcnt_r <= tcnt_nxt;
      tick_r <= tick_nxt;
      maxofs_r <= maxofs_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_chan
      cos_chan u_chan (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tick_i(tick_r),
        .coupled_i(mask_r[g]),
        .on_evt_i(evt[0]),
        .off_evt_i(evt[1]),
        .cofs_i(cofs_r),
        .mofs_i(mod_ofs_i[g]),
        .cfg_i(cfg_r[g]),
        .on_o(chan_on[g])
      );
    end
  endgenerate

  assign chan_on_o = chan_on;
  assign dig_out_o = out_r;
  assign dig_oe_o = oe_r;
  assign rdata_o = rdata_r;

  sequence s_drive_hold;
    drive_r[0] [*8];
  endsequence

  property p_drive_on;
    @(posedge clk_i) disable iff (!nrst_i)
    start[0] |=> s_drive_hold;
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("on line not held low after local request");

  property p_echo;
    @(posedge clk_i) disable iff (!nrst_i)
    (fall[0] && lcnt_r[0] != '0 && !loc[0]) |-> !evt[0];
  endproperty
  a_echo: assert property (p_echo)
    else $error("own edge raised a second on event");

  property p_remote;
    @(posedge clk_i) disable iff (!nrst_i)
    (en_r && fall[1] && lcnt_r[1] == '0) |-> evt[1];
  endproperty
  a_remote: assert property (p_remote)
    else $error("remote falling edge ignored");

  property p_refuse;
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_pin && !pin_good) |=> $stable(on_pin_r) && $stable(off_pin_r) && err_r;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("bad sync line assignment not refused");

  property p_one_line;
    @(posedge clk_i) disable iff (!nrst_i)
    $onehot0(hot[0]) && $onehot0(hot[1]) && !(|(hot[0] & hot[1]));
  endproperty
  a_one_line: assert property (p_one_line)
    else $error("more than one line per sync function");

  property p_polarity;
    @(posedge clk_i) disable iff (!nrst_i)
    (|hot[0]) |=> ((dig_out_o & $past(hot[0])) == '0);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("on line output level follows polarity");

  property p_disabled;
    @(posedge clk_i) disable iff (!nrst_i)
    !en_r |-> (evt == 2'h0) && (start == 2'h0);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("event while synchronization disabled");
endmodule : cos_sync
`default_nettype wire

// *** rtl/cos_pad_unused.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** tb/cos_far_frame.sv ***
`timescale 1ns/1ps
`default_nettype none
module cos_far_frame #(
  parameter int PULSE_CYC = 200
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Local requests of the far frame
  input wire logic fire_on_i,
  input wire logic fire_off_i,
  // Joined line levels
  input wire logic on_lvl_i,
  input wire logic off_lvl_i,
  // Open-drain pull-downs and falls seen
  output logic on_drv_o,
  output logic off_drv_o,
  output logic [7:0] on_falls_o,
  output logic [7:0] off_falls_o
);
  int on_cnt;
  int off_cnt;
  logic on_prev;
  logic off_prev;
  // Initiator pulls its line low for a whole pulse, then lets go
  assign on_drv_o = (on_cnt > 0);
  assign off_drv_o = (off_cnt > 0);
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      on_cnt <= 0;
      off_cnt <= 0;
      on_prev <= 1'b1;
      off_prev <= 1'b1;
      on_falls_o <= 8'h00;
      off_falls_o <= 8'h00;
    end else begin
      on_cnt <= fire_on_i ? PULSE_CYC : (on_cnt > 0 ? on_cnt - 1 : 0);
      off_cnt <= fire_off_i ? PULSE_CYC : (off_cnt > 0 ? off_cnt - 1 : 0);
      on_prev <= on_lvl_i;
      off_prev <= off_lvl_i;
      // Any fall on the joined lines is an event for this frame
      if (on_prev && !on_lvl_i) on_falls_o <= on_falls_o + 8'h01;
      if (off_prev && !off_lvl_i) off_falls_o <= off_falls_o + 8'h01;
    end
  end
endmodule : cos_far_frame
`default_nettype wire

// *** tb/coupled_output_turn_on_sync_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cos_defs.svh"
`define CHK(got, exp, msg) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("ERROR %0t %s", $time, msg); \
  end \
end
module coupled_output_turn_on_sync_tb;
  import cos_pkg::*;
  localparam int N = 4;
  localparam int TK = `COS_TICK_CYC;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  cos_bus_req_t bus = '0;
  logic [31:0] rdata;
  logic req_on = 1'b0;
  logic req_off = 1'b0;
  logic [N-1:0] mod_present = '0;
  logic [N-1:0][`COS_DLY_W-1:0] mod_ofs = '0;
  logic [`COS_NPIN-1:0] dig_lvl;
  logic [`COS_NPIN-1:0] dig_out;
  logic [`COS_NPIN-1:0] dig_oe;
  logic [N-1:0] chan_on;
  logic fire_on = 1'b0;
  logic fire_off = 1'b0;
  logic far_on_drv;
  logic far_off_drv;
  logic [7:0] on_falls;
  logic [7:0] off_falls;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  int on_drive;
  int off_drive;
  int bad_pol;
  int hit [N];
  logic [31:0] d;

  always #5 clk_i = ~clk_i;

  // Pull-ups on all pins; any party may pull low
  assign dig_lvl = ~(dig_oe & ~dig_out) & ~{far_off_drv, far_on_drv, 5'h00};

  cos_sync #(.N(N)) u_cos_sync (
    .clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata),
    .req_on_i(req_on), .req_off_i(req_off),
    .mod_present_i(mod_present), .mod_ofs_i(mod_ofs),
    .dig_in_i(dig_lvl), .dig_out_o(dig_out), .dig_oe_o(dig_oe),
    .chan_on_o(chan_on)
  );

  cos_far_frame #(.PULSE_CYC(`COS_SYNC_PULSE_CYC)) u_cos_far_frame (
    .clk_i(clk_i), .nrst_i(nrst_i), .fire_on_i(fire_on),
    .fire_off_i(fire_off), .on_lvl_i(dig_lvl[5]), .off_lvl_i(dig_lvl[6]),
    .on_drv_o(far_on_drv), .off_drv_o(far_off_drv),
    .on_falls_o(on_falls), .off_falls_o(off_falls)
  );

  task automatic finish_test();
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    bus.addr <= a;
    bus.wdata <= v;
    bus.we <= 1'b1;
    @(posedge clk_i);
    bus.we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    bus.addr <= a;
    bus.re <= 1'b1;
    @(posedge clk_i);
    bus.re <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  // First cycle each channel shows v, plus sync line activity
  task automatic watch(input logic v, input int ncyc);
    on_drive = 0;
    off_drive = 0;
    bad_pol = 0;
    for (int i = 0; i < N; i++) hit[i] = -1;
    // Sample the edge that launched the request too, so no cycle is lost
    for (int c = 0; c < ncyc; c++) begin
      #1;
      for (int i = 0; i < N; i++) if (hit[i] < 0 && chan_on[i] === v) hit[i] = c;
      if (dig_oe[5] === 1'b1) on_drive++;
      if (dig_oe[6] === 1'b1) off_drive++;
      if (dig_oe[5] === 1'b1 && dig_out[5] !== 1'b0) bad_pol++;
      @(posedge clk_i);
    end
  endtask : watch

  // Counts are tick-quantised, so one tick of slack either way
  task automatic chk_time(input int i, input int ticks);
    if (ticks < 0) `CHK(hit[i], -1, "channel moved")
    else `CHK(hit[i] >= (ticks - 1) * TK && hit[i] <= (ticks + 1) * TK + 4,
              1'b1, "switch time off")
  endtask : chk_time

  task automatic pulse_far(input logic off);
    @(posedge clk_i);
    if (off) fire_off <= 1'b1;
    else fire_on <= 1'b1;
    @(posedge clk_i);
    fire_off <= 1'b0;
    fire_on <= 1'b0;
  endtask : pulse_far

  task automatic t_regs();
    int on_t [N] = '{3, 1, 2, 2};
    int off_t [N] = '{1, 3, 0, 0};
    rd(`COS_REG_CTRL, d);
    `CHK(d, 32'h0000_0000, "ctrl reset")
    wr(`COS_REG_CHAN, 32'h0000_000B);
    rd(`COS_REG_CHAN, d);
    `CHK(d, 32'h0000_000B, "coupled mask")
    // Larger than any installed module offset
    wr(`COS_REG_COFS, 32'h0000_0009);
    rd(`COS_REG_COFS, d);
    `CHK(d, 32'h0000_0009, "large offset")
    rd(`COS_REG_STATUS, d);
    `CHK(d[`COS_STAT_ERR], 1'b0, "large offset flagged")
    @(posedge clk_i);
    mod_present <= 4'h3;
    mod_ofs <= {24'h000000, 24'h000007, 24'h000001, 24'h000002};
    rd(`COS_REG_MAXOFS, d);
    `CHK(d, 32'h0000_0002, "max module offset")
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC, d);
    `CHK(d, 32'h0000_0000, "unmapped read")
    for (int i = 0; i < N; i++) begin
      wr(8'(`COS_REG_ONDLY + 4 * i), 32'(on_t[i]));
      wr(8'(`COS_REG_OFFDLY + 4 * i), 32'(off_t[i]));
    end
    rd(8'(`COS_REG_ONDLY + 4), d);
    `CHK(d, 32'h0000_0001, "on delay readback")
    // Common offset equals the worst installed module offset
    wr(`COS_REG_COFS, 32'h0000_0002);
  endtask : t_regs

  task automatic t_pins();
    // On line on pin 3, which cannot carry sync
    wr(`COS_REG_PINCFG, 32'h0000_0073);
    rd(`COS_REG_PINCFG, d);
    `CHK(d, 32'h0000_0000, "bad pin taken")
    rd(`COS_REG_STATUS, d);
    `CHK(d[`COS_STAT_ERR], 1'b1, "bad pin not flagged")
    wr(`COS_REG_STATUS, 32'h0000_0100);
    wr(`COS_REG_PINCFG, 32'h0000_0066);
    rd(`COS_REG_PINCFG, d);
    `CHK(d, 32'h0000_0000, "shared pin taken")
    rd(`COS_REG_STATUS, d);
    `CHK(d[`COS_STAT_ERR], 1'b1, "shared pin not flagged")
    wr(`COS_REG_PINCFG, 32'h0000_0076);
    rd(`COS_REG_PINCFG, d);
    `CHK(d, 32'h0000_0076, "pin pair")
    // Invert every pin; sync lines must ignore it
    wr(`COS_REG_GPIO, 32'h0000_7F00);
  endtask : t_pins

  task automatic t_on_local();
    // Enable must already stand when the on request is written
    wr(`COS_REG_CTRL, 32'h0000_0001);
    rd(`COS_REG_CTRL, d);
    `CHK(d, 32'h0000_0001, "sync enable")
    wr(`COS_REG_CTRL, 32'h0000_0003);
    watch(1'b1, 8 * TK);
    chk_time(0, 5);
    chk_time(1, 3);
    chk_time(2, -1);
    chk_time(3, 4);
    `CHK(on_drive, `COS_SYNC_PULSE_CYC, "own pulse")
    `CHK(bad_pol, 0, "sync level")
    `CHK(on_falls, 8'h01, "far frame falls")
  endtask : t_on_local

  task automatic t_off_remote();
    pulse_far(1'b1);
    watch(1'b0, 5 * TK);
    chk_time(0, 1);
    chk_time(1, 3);
    chk_time(3, 0);
    `CHK(off_drive, 0, "echoed off")
    `CHK(off_falls, 8'h01, "off falls")
  endtask : t_off_remote

  task automatic t_on_offset0();
    wr(`COS_REG_COFS, 32'h0000_0000);
    @(posedge clk_i);
    req_on <= 1'b1;
    @(posedge clk_i);
    req_on <= 1'b0;
    watch(1'b1, 7 * TK);
    chk_time(0, 5);
    chk_time(1, 2);
    chk_time(3, 2);
    chk_time(2, -1);
    `CHK(on_drive, `COS_SYNC_PULSE_CYC, "panel pulse")
    `CHK(on_falls, 8'h02, "panel falls")
  endtask : t_on_offset0

  task automatic t_disabled();
    wr(`COS_REG_CTRL, 32'h0000_0000);
    pulse_far(1'b1);
    req_off <= 1'b1;
    @(posedge clk_i);
    req_off <= 1'b0;
    watch(1'b0, 4 * TK);
    chk_time(0, -1);
    chk_time(1, -1);
    chk_time(3, -1);
    `CHK(off_drive, 0, "off driven")
  endtask : t_disabled

  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_pins();
    t_on_local();
    t_off_remote();
    t_on_offset0();
    t_disabled();
    finish_test();
  end
endmodule : coupled_output_turn_on_sync_tb
`default_nettype wire
